// >>> rtl/obs_link_if.sv
// Link between the sequencer (device) and the one-bit processor end.
// The shared data bus is resolved here from both enables; idle level is 1.
`timescale 1ns/1ps
interface obs_link_if;
  logic       proc_clk;
  logic       proc_reset;
  logic [3:0] mem_data;
  logic       bus_dev_out;
  logic       bus_dev_oe_n;
  logic       bus_proc_out;
  logic       bus_proc_oe_n;
  logic       write_strobe;
  logic       end_flag_pulse;
  logic       result_bit;
  logic       data_bus;

  assign data_bus = !bus_dev_oe_n  ? bus_dev_out  :
                    !bus_proc_oe_n ? bus_proc_out : 1'b1;

  modport dev (
    output proc_clk, proc_reset, mem_data, bus_dev_out, bus_dev_oe_n,
    input  bus_proc_out, bus_proc_oe_n, write_strobe, end_flag_pulse,
    input  result_bit, data_bus
  );
  modport proc (
    input  proc_clk, proc_reset, mem_data, bus_dev_out, bus_dev_oe_n, data_bus,
    output bus_proc_out, bus_proc_oe_n, write_strobe, end_flag_pulse, result_bit
  );
endinterface

// >>> rtl/obs_pkg.sv
// Shared constants for the one-bit controller sequencer and its processor end.
// Assumes a single 100 MHz system clock shared by both ends.
package obs_pkg;
  // System timing
  localparam int SYS_CLK_HZ   = 100_000_000;
  localparam int RUN_CLK_HZ   = 1_000_000;
  localparam int RUN_HALF_CYC = SYS_CLK_HZ / (2 * RUN_CLK_HZ);
  localparam int DEBOUNCE_US  = 10_000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * (SYS_CLK_HZ / 1_000_000);

  // Memory and I/O geometry
  localparam int PC_W      = 7;
  localparam int MEM_WORDS = 256;
  localparam int DATA_W    = 4;
  localparam int IO_COUNT  = 16;
  localparam int BTN_COUNT = 5;

  // Button positions in the debounced vector
  localparam int BTN_RUN  = 0;
  localparam int BTN_HALT = 1;
  localparam int BTN_STEP = 2;
  localparam int BTN_LOAD = 3;
  localparam int BTN_PCLD = 4;

  // Reset values and the result input address
  localparam logic [PC_W-1:0]   PC_RST   = 7'h00;
  localparam logic [DATA_W-1:0] DATA_RST = 4'h0;
  localparam logic [IO_COUNT-1:0] OUT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] RESULT_INPUT = 4'h0;

  // Instruction codes
  typedef enum logic [3:0] {
    OP_NULL  = 4'h0, OP_LD   = 4'h1, OP_LDC  = 4'h2, OP_AND  = 4'h3,
    OP_ANDC  = 4'h4, OP_OR   = 4'h5, OP_ORC  = 4'h6, OP_XNOR = 4'h7,
    OP_STORE = 4'h8, OP_STOC = 4'h9, OP_IEN  = 4'ha, OP_OEN  = 4'hb,
    OP_JMP   = 4'hc, OP_RTN  = 4'hd, OP_SKZ  = 4'he, OP_END  = 4'hf
  } obs_op_t;
endpackage

// >>> rtl/obs_proc_end.sv
// One-bit processor end: fetches on the high phase, executes on the low phase.
// Assumes proc_clk and proc_reset are flops of the sequencer on the same clk_sys.
`timescale 1ns/1ps
module obs_proc_end (
  // System
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       ce,
  // Link
  obs_link_if.proc        link,
  // Observation
  output logic [3:0]      instr_code,
  output logic            in_gate,
  output logic            out_gate
);
  logic       clk_d_ff;
  logic [3:0] instr_ff;
  logic       res_ff;
  logic       ien_ff;
  logic       oen_ff;
  logic       skip_ff;
  logic       skipping_ff;
  logic       flag_ff;
  logic       drv_ff;
  logic       dout_ff;
  logic       wr_ff;
  logic       nxt_res;
  logic       nxt_skip;

  wire rise_w = link.proc_clk & ~clk_d_ff;
  wire fall_w = ~link.proc_clk & clk_d_ff;
  wire din_w  = link.data_bus & ien_ff;
  wire [3:0] fetch_w = link.mem_data;
  wire is_store_w = (fetch_w == obs_pkg::OP_STORE) || (fetch_w == obs_pkg::OP_STOC);

  always_comb begin
    nxt_res  = res_ff;
    nxt_skip = 1'b0;
    if (!skipping_ff) begin
      unique case (instr_ff)
        obs_pkg::OP_LD:   nxt_res = din_w;
        obs_pkg::OP_LDC:  nxt_res = ~din_w;
        obs_pkg::OP_AND:  nxt_res = res_ff & din_w;
        obs_pkg::OP_ANDC: nxt_res = res_ff & ~din_w;
        obs_pkg::OP_OR:   nxt_res = res_ff | din_w;
        obs_pkg::OP_ORC:  nxt_res = res_ff | ~din_w;
        obs_pkg::OP_XNOR: nxt_res = ~(res_ff ^ din_w);
        obs_pkg::OP_SKZ:  nxt_skip = ~res_ff;
        default:          nxt_res = res_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      clk_d_ff    <= 1'b1;
      instr_ff    <= obs_pkg::DATA_RST;
      res_ff      <= 1'b0;
      ien_ff      <= 1'b0;
      oen_ff      <= 1'b0;
      skip_ff     <= 1'b0;
      skipping_ff <= 1'b0;
      flag_ff     <= 1'b0;
      drv_ff      <= 1'b0;
      dout_ff     <= 1'b0;
      wr_ff       <= 1'b0;
    end else if (ce) begin
      clk_d_ff <= link.proc_clk;
      if (link.proc_reset) begin
        instr_ff    <= obs_pkg::DATA_RST;
        res_ff      <= 1'b0;
        ien_ff      <= 1'b0;
        oen_ff      <= 1'b0;
        skip_ff     <= 1'b0;
        skipping_ff <= 1'b0;
        flag_ff     <= 1'b0;
        drv_ff      <= 1'b0;
        wr_ff       <= 1'b0;
      end else if (fall_w) begin
        instr_ff    <= fetch_w;
        skipping_ff <= skip_ff;
        skip_ff     <= 1'b0;
        flag_ff     <= (fetch_w == obs_pkg::OP_END) && !skip_ff;
        drv_ff      <= is_store_w && !skip_ff;
        dout_ff     <= (fetch_w == obs_pkg::OP_STOC) ? ~res_ff : res_ff;
        wr_ff       <= is_store_w && !skip_ff && oen_ff;
      end else if (rise_w) begin
        drv_ff  <= 1'b0;
        wr_ff   <= 1'b0;
        res_ff  <= nxt_res;
        skip_ff <= nxt_skip;
        if (!skipping_ff && instr_ff == obs_pkg::OP_IEN) begin
          ien_ff <= link.data_bus;
        end
        if (!skipping_ff && instr_ff == obs_pkg::OP_OEN) begin
          oen_ff <= link.data_bus;
        end
      end
    end
  end

  assign link.bus_proc_out   = dout_ff;
  assign link.bus_proc_oe_n  = ~drv_ff;
  assign link.write_strobe   = wr_ff;
  assign link.end_flag_pulse = flag_ff;
  assign link.result_bit     = res_ff;
  assign instr_code = instr_ff;
  assign in_gate    = ien_ff;
  assign out_gate   = oen_ff;
endmodule

// >>> rtl/obs_sequencer.sv
// Statement sequencer, program memory, I/O selectors, output latches and
// front panel around a one-bit processor. Buttons are raw contacts; the
// processor end shares clk_sys and meets this block through obs_link_if.
`timescale 1ns/1ps
module obs_sequencer #(
  parameter int DEBOUNCE_CYC = obs_pkg::DEBOUNCE_CYC,
  parameter int RUN_HALF_CYC = obs_pkg::RUN_HALF_CYC,
  parameter logic [obs_pkg::MEM_WORDS*obs_pkg::DATA_W-1:0] PROM_IMAGE = '0
) (
  // System
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          ce,
  // Front panel buttons, raw
  input  wire logic                          run_btn,
  input  wire logic                          halt_btn,
  input  wire logic                          step_btn,
  input  wire logic                          load_btn,
  input  wire logic                          pc_load_btn,
  // Front panel switches
  input  wire logic                          run_mode,
  input  wire logic                          memory_source_select,
  input  wire logic [obs_pkg::DATA_W-1:0]    data_sw,
  input  wire logic [obs_pkg::PC_W-1:0]      pc_sw,
  // Field inputs, index 0 unused
  input  wire logic [obs_pkg::IO_COUNT-1:0]  field_in,
  // Field outputs and lights
  output logic [obs_pkg::IO_COUNT-1:0]       field_out,
  output logic [obs_pkg::PC_W-1:0]           pc_lights,
  output logic [obs_pkg::DATA_W-1:0]         mem_lights,
  output logic                               opcode_light,
  output logic                               addr_light,
  output logic                               result_light,
  // Link
  obs_link_if.dev                            link
);
  localparam int DBW = $clog2(DEBOUNCE_CYC + 1);
  localparam int DVW = $clog2(RUN_HALF_CYC + 1);
  localparam int AW  = $clog2(obs_pkg::MEM_WORDS);
  localparam int NB  = obs_pkg::BTN_COUNT;

  // Button debouncing
  logic [NB-1:0] btn_raw;
  logic [NB-1:0] btn_pulse;

  assign btn_raw[obs_pkg::BTN_RUN]  = run_btn;
  assign btn_raw[obs_pkg::BTN_HALT] = halt_btn;
  assign btn_raw[obs_pkg::BTN_STEP] = step_btn;
  assign btn_raw[obs_pkg::BTN_LOAD] = load_btn;
  assign btn_raw[obs_pkg::BTN_PCLD] = pc_load_btn;

  // debounce every button
  // Flops are local to each button so every one has a single driving process
  for (genvar b = 0; b < NB; b++) begin : g_btn
    logic [DBW-1:0] cnt_ff;
    logic           s1_ff;
    logic           s2_ff;
    logic           st_ff;
    logic           st_d_ff;
    wire            diff_w = s2_ff ^ st_ff;
    wire            done_w = (cnt_ff == DBW'(DEBOUNCE_CYC - 1));
    always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
        s1_ff   <= 1'b0;
        s2_ff   <= 1'b0;
        st_ff   <= 1'b0;
        st_d_ff <= 1'b0;
        cnt_ff  <= '0;
      end else if (ce) begin
        s1_ff   <= btn_raw[b];
        s2_ff   <= s1_ff;
        st_d_ff <= st_ff;
        if (!diff_w) begin
          cnt_ff <= '0;
        end else if (done_w) begin
          cnt_ff <= '0;
          st_ff  <= s2_ff;
        end else begin
          cnt_ff <= cnt_ff + DBW'(1);
        end
      end
    end
    assign btn_pulse[b] = st_ff & ~st_d_ff;
  end

  wire run_p  = btn_pulse[obs_pkg::BTN_RUN];
  wire halt_p = btn_pulse[obs_pkg::BTN_HALT];
  wire step_p = btn_pulse[obs_pkg::BTN_STEP];
  wire load_p = btn_pulse[obs_pkg::BTN_LOAD];
  wire pcld_p = btn_pulse[obs_pkg::BTN_PCLD];

  // State
  logic                         halted_ff;
  logic                         pclk_ff;
  logic [DVW-1:0]               div_ff;
  logic [obs_pkg::PC_W-1:0]     pc_ff;
  logic [obs_pkg::DATA_W-1:0]   ram_ff [obs_pkg::MEM_WORDS];
  logic [obs_pkg::DATA_W-1:0]   mem_rd_ff;
  logic [obs_pkg::DATA_W-1:0]   opcode_ff;
  logic                         low_ph_ff;
  logic                         bus_out_ff;
  logic                         bus_drv_ff;
  logic [obs_pkg::IO_COUNT-1:0] out_ff;
  logic                         op_light_ff;
  logic                         ad_light_ff;
  logic                         res_light_ff;

  // step toggles clock when run_mode is low; free run only out of halt
  wire div_done = (div_ff == DVW'(RUN_HALF_CYC - 1));
  wire free_tog = run_mode && !halted_ff && div_done;
  wire step_tog = !run_mode && step_p;
  wire toggle   = !halt_p && (free_tog || step_tog);
  wire pc_rise  = toggle && !pclk_ff;
  wire pc_fall  = toggle && pclk_ff;

  wire [AW-1:0] mem_addr = {pc_ff, pclk_ff};
  wire [obs_pkg::DATA_W-1:0] prom_w = PROM_IMAGE[mem_addr*obs_pkg::DATA_W +: obs_pkg::DATA_W];
  wire [obs_pkg::DATA_W-1:0] mem_w  = memory_source_select ? prom_w : ram_ff[mem_addr];
  wire ram_we = load_p && !memory_source_select;

  // input selector; address zero is the result
  wire [obs_pkg::IO_COUNT-1:0] sel_in = {field_in[obs_pkg::IO_COUNT-1:1], link.result_bit};
  wire sel_bit = sel_in[mem_rd_ff];
  wire is_store = (opcode_ff == obs_pkg::OP_STORE) || (opcode_ff == obs_pkg::OP_STOC);

  // Free-run divider restarts on every toggle so steps land on whole half cycles
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_ff <= '0;
    end else if (ce) begin
      div_ff <= (toggle || !run_mode || halted_ff) ? '0 : div_ff + DVW'(1);
    end
  end

  // run clears, halt sets the held reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      halted_ff <= 1'b1;
    end else if (ce) begin
      if (halt_p) begin
        halted_ff <= 1'b1;
      end else if (run_p) begin
        halted_ff <= 1'b0;
      end
    end
  end

  // one counter value per high and low phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pclk_ff <= 1'b1;
      pc_ff   <= obs_pkg::PC_RST;
    end else if (ce) begin
      if (halt_p) begin
        pclk_ff <= 1'b1;
        pc_ff   <= obs_pkg::PC_RST;
      end else if (pcld_p) begin
        pc_ff <= pc_sw;
      end else if (toggle) begin
        pclk_ff <= ~pclk_ff;
        if (pc_rise) begin
          // end flag presets; otherwise count and wrap
          pc_ff <= (link.end_flag_pulse && !halted_ff) ? pc_sw : pc_ff + 7'h01;
        end
      end
    end
  end

  // load writes RAM unless memory_source_select picks the PROM; 256 by 4 storage
  always_ff @(posedge clk_sys) begin
    if (ce && ram_we) begin
      ram_ff[mem_addr] <= data_sw;
    end
  end

  // Memory read is registered; it trails the address by one cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mem_rd_ff <= obs_pkg::DATA_RST;
      opcode_ff <= obs_pkg::DATA_RST;
    end else if (ce) begin
      mem_rd_ff <= mem_w;
      if (pc_fall) begin
        opcode_ff <= mem_rd_ff;
      end
    end
  end

  // Bus drive lags the clock by two cycles so the processor still sees the bit
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      low_ph_ff  <= 1'b0;
      bus_out_ff <= 1'b0;
      bus_drv_ff <= 1'b0;
    end else if (ce) begin
      low_ph_ff  <= ~pclk_ff;
      bus_out_ff <= sel_bit;
      bus_drv_ff <= low_ph_ff && !is_store && !halted_ff;
    end
  end

  // latch on rising edge; halt clears
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      out_ff <= obs_pkg::OUT_RST;
    end else if (ce) begin
      if (halt_p) begin
        out_ff <= obs_pkg::OUT_RST;
      end else if (pc_rise && link.write_strobe) begin
        out_ff[mem_rd_ff] <= link.data_bus;
      end
    end
  end

  // phase lights; data lights follow memory
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      op_light_ff  <= 1'b0;
      ad_light_ff  <= 1'b0;
      res_light_ff <= 1'b0;
    end else if (ce) begin
      op_light_ff  <= pclk_ff;
      ad_light_ff  <= ~pclk_ff;
      res_light_ff <= link.result_bit;
    end
  end

  assign link.proc_clk     = pclk_ff;
  assign link.proc_reset   = halted_ff;
  assign link.mem_data     = mem_rd_ff;
  assign link.bus_dev_out  = bus_out_ff;
  assign link.bus_dev_oe_n = ~bus_drv_ff;
  assign field_out    = out_ff;
  assign pc_lights    = pc_ff;
  assign mem_lights   = mem_rd_ff;
  assign opcode_light = op_light_ff;
  assign addr_light   = ad_light_ff;
  assign result_light = res_light_ff;
endmodule

// >>> verif/obs_link_sva.sv
// Concurrent checks on the link between the sequencer and the processor end.
// Assumes one clk_sys domain and half phases of at least 4 cycles.
`timescale 1ns/1ps
module obs_link_sva (
  // System
  input wire logic       clk_sys,
  input wire logic       reset,
  // Link
  input wire logic       proc_clk,
  input wire logic       proc_reset,
  input wire logic       bus_dev_oe_n,
  input wire logic       bus_proc_oe_n,
  input wire logic       write_strobe,
  input wire logic       end_flag_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  bus_excl_a: assert property (!(!bus_dev_oe_n && !bus_proc_oe_n))
    else $error("both ends drive the data bus");
  drive_start_a: assert property ($fell(bus_dev_oe_n) |-> !proc_clk && !$past(proc_clk))
    else $error("selector drives outside the low phase");
  drive_end_a: assert property ($rose(proc_clk) |-> ##[1:3] (bus_dev_oe_n && bus_proc_oe_n))
    else $error("bus still driven after the rising clock");
  strobe_start_a: assert property ($rose(write_strobe) |-> !proc_clk && !proc_reset)
    else $error("write strobe outside an executing low phase");
  strobe_end_a: assert property ($rose(proc_clk) |-> ##[0:2] !write_strobe)
    else $error("write strobe held into the high phase");
  phase_len_a: assert property ($changed(proc_clk) && !proc_reset |=>
    (proc_reset || $stable(proc_clk))[*2]) else $error("clock phase too short");
  flag_rise_a: assert property ($rose(end_flag_pulse) |-> !proc_clk)
    else $error("end flag rose outside the low phase");
  flag_len_a: assert property ($rose(end_flag_pulse) |=> (end_flag_pulse || proc_reset)[*3])
    else $error("end flag pulse too short");
  halt_clock_a: assert property ($rose(proc_reset) |-> proc_clk)
    else $error("halt did not set the clock high");
  halt_quiet_a: assert property (proc_reset && $past(proc_reset) |->
    bus_dev_oe_n && !write_strobe) else $error("activity while halted");

  cover property ($rose(write_strobe));
  cover property ($rose(end_flag_pulse));
  cover property ($fell(bus_dev_oe_n));
endmodule

// >>> verif/tb_obs_sequencer.sv
// Self-checking bench: sequencer and processor end joined by the link.
// Assumes rtl/ compiled first; debounce and run half period are shortened.
`timescale 1ns/1ps
module tb_obs_sequencer;
  localparam int          DEB  = 4;
  localparam int          RN   = obs_pkg::BTN_RUN;
  localparam int          HT   = obs_pkg::BTN_HALT;
  localparam int          ST   = obs_pkg::BTN_STEP;
  localparam int          LD   = obs_pkg::BTN_LOAD;
  localparam int          PL   = obs_pkg::BTN_PCLD;
  // Enable, load, store to 2, inverted store to 3, end
  localparam logic [55:0] PROG = 56'ha6b6_1110_8293_f0;
  localparam logic [1023:0] PROM = 1024'h3c;
  // Gates from inputs 6 and 7, inverted load of 1, store to 5, end
  localparam logic [39:0] GATE = 40'ha6b7_2185_f0;

  logic        clk_sys  = 1'b0;
  logic        reset    = 1'b1;
  logic [4:0]  btn      = '0;
  logic        run_mode = 1'b0;
  logic        src      = 1'b0;
  logic [3:0]  data_sw  = '0;
  logic [6:0]  pc_sw    = '0;
  logic [15:0] field_in = '0;
  logic [15:0] field_out;
  logic [6:0]  pc_lights;
  logic [3:0]  mem_lights;
  logic        opcode_light;
  logic        addr_light;
  logic        result_light;
  logic        in_gate;
  logic        out_gate;
  int          failures = 0;
  int          checks   = 0;
  int          cycles   = 0;

  obs_link_if link_i ();
  obs_sequencer #(.DEBOUNCE_CYC(DEB), .RUN_HALF_CYC(4), .PROM_IMAGE(PROM)) obs_sequencer_i (
    .clk_sys(clk_sys), .reset(reset), .ce(1'b1),
    .run_btn(btn[RN]), .halt_btn(btn[HT]), .step_btn(btn[ST]),
    .load_btn(btn[LD]), .pc_load_btn(btn[PL]),
    .run_mode(run_mode), .memory_source_select(src), .data_sw(data_sw), .pc_sw(pc_sw),
    .field_in(field_in), .field_out(field_out), .pc_lights(pc_lights),
    .mem_lights(mem_lights), .opcode_light(opcode_light), .addr_light(addr_light),
    .result_light(result_light), .link(link_i.dev));
  obs_proc_end obs_proc_end_i (
    .clk_sys(clk_sys), .reset(reset), .ce(1'b1), .link(link_i.proc),
    .instr_code(), .in_gate(in_gate), .out_gate(out_gate));
  obs_link_sva obs_link_sva_i (
    .clk_sys(clk_sys), .reset(reset), .proc_clk(link_i.proc_clk),
    .proc_reset(link_i.proc_reset), .bus_dev_oe_n(link_i.bus_dev_oe_n),
    .bus_proc_oe_n(link_i.bus_proc_oe_n), .write_strobe(link_i.write_strobe),
    .end_flag_pulse(link_i.end_flag_pulse));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Held well past the debounce window so each press acts once
  task automatic press(int b);
    btn[b] <= 1'b1;
    tick(DEB + 6);
    btn[b] <= 1'b0;
    tick(DEB + 6);
  endtask

  function automatic logic [3:0] word(int i);
    return PROG[4*(13-i) +: 4];
  endfunction

  task automatic check(logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_panel();
    check(field_out | 16'(pc_lights), 16'h0000);
    check(16'({opcode_light, addr_light}), 16'h0002);
    press(HT);
    press(ST);
    check(16'({opcode_light, addr_light, pc_lights}), 16'h0080);
    press(ST);
    check(16'({opcode_light, addr_light, pc_lights}), 16'h0101);
    $display("panel test done");
  endtask

  task automatic t_enter();
    press(HT);
    for (int i = 0; i < 14; i++) begin
      data_sw <= word(i);
      press(LD);
      check(16'(mem_lights), 16'(word(i)));
      press(ST);
    end
    check(16'(pc_lights), 16'h0007);
    press(HT);
    for (int i = 0; i < 14; i++) begin
      check(16'(mem_lights), 16'(word(i)));
      press(ST);
    end
    $display("enter test done");
  endtask

  task automatic t_run();
    logic [6:0] lo;
    logic [6:0] hi;
    lo = 7'h7f;
    hi = 7'h00;
    field_in <= 16'h0042;
    pc_sw <= 7'h02;
    run_mode <= 1'b1;
    press(HT);
    press(RN);
    tick(300);
    check(field_out, 16'h0004);
    check(16'(result_light), 16'h0001);
    field_in <= 16'h0041;
    repeat (200) begin
      tick(1);
      if (pc_lights < lo) lo = pc_lights;
      if (pc_lights > hi) hi = pc_lights;
    end
    check(field_out, 16'h0008);
    check(16'({lo, hi}), 16'h0106);
    press(HT);
    check(field_out | 16'(pc_lights), 16'h0000);
    $display("run test done");
  endtask

  // A closed output gate must hold back a store that would set the latch
  task automatic t_gate();
    run_mode <= 1'b0;
    press(HT);
    for (int i = 0; i < 10; i++) begin
      data_sw <= GATE[4*(9-i) +: 4];
      press(LD);
      press(ST);
    end
    pc_sw    <= 7'h00;
    field_in <= 16'h0040;
    run_mode <= 1'b1;
    press(HT);
    press(RN);
    tick(200);
    check(16'({in_gate, out_gate}), 16'h0002);
    check(field_out, 16'h0000);
    field_in <= 16'h00c0;
    tick(200);
    check(16'({in_gate, out_gate}), 16'h0003);
    check(field_out, 16'h0020);
    press(HT);
    $display("gate test done");
  endtask

  task automatic t_prom();
    int n;
    src <= 1'b1;
    press(HT);
    check(16'(mem_lights), 16'h0003);
    data_sw <= 4'h9;
    press(LD);
    check(16'(mem_lights), 16'h0003);
    pc_sw <= 7'h55;
    press(PL);
    check(16'(pc_lights), 16'h0055);
    press(RN);
    n = 0;
    while (pc_lights !== 7'h7f && n < 1500) begin
      tick(1);
      n++;
    end
    check(16'(pc_lights), 16'h007f);
    n = 0;
    while (pc_lights === 7'h7f && n < 20) begin
      tick(1);
      n++;
    end
    check(16'(pc_lights), 16'h0000);
    press(HT);
    $display("prom test done");
  endtask

  // Hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    tick(10);
    reset <= 1'b0;
    tick(2);
    t_panel();
    t_enter();
    t_run();
    t_gate();
    t_prom();
    stop_test();
  end
endmodule
